/* fsr_defs.vh */
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH
// Operation
// - Status is captured on chip or output enable fall and held until release.
// - Status is returned only by single-word reads, never by bursts.
// - Reads in a bank with a running operation return status, unless read-array.
// - Idle, suspend and bank-write bits follow the device state by themselves.
// - Error bits stay set until clear-status command or hardware reset.
// - Idle bit is 0 while controller active, 1 when inactive.
// - After suspend, idle bit stays 0 until the controller has paused.
// - Erase-suspended bit is 1 while erase waits for resume, else 0.
// - Erase-suspended sets within suspend latency; finishing erase may win.
// - Resume command returns the erase-suspended bit to 0.
// - Each error bit reads 1 for failure and 0 for success.
// - Program-suspended bit is 1 while program suspended, else 0.
// - Normal mode busy: bank-write 1 for other bank, 0 for addressed bank.
// - Factory mode busy: bank-write 0 ready for buffer, 1 not ready.
// - Blank check sets erase-check error if any word differs from all ones.
// - Programming voltage is sampled only at the start of program or erase.
`define FSR_BIT_IDLE 7
`define FSR_BIT_ESUSP 6
`define FSR_BIT_ECHK 5
`define FSR_BIT_PERR 4
`define FSR_BIT_VERR 3
`define FSR_BIT_PSUSP 2
`define FSR_BIT_PROT 1
`define FSR_BIT_BANK 0
`define FSR_ERASED_WORD 16'hFFFF
`define FSR_RESET_ERR 4'h0
`define FSR_SUSP_LAT_NS 20000
`define FSR_CLK_NS 100
`define FSR_SUSP_CYC ((`FSR_SUSP_LAT_NS) / (`FSR_CLK_NS))
`define FSR_NUM_BANKS 16
`endif

/* fsr_sync3.v */
`timescale 1ns/1ps
// Three-stage synchroniser for a group of pins; a change counts once the
// second and third stages agree.
module fsr_sync3 #(
  parameter W = 2
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  // Shift the pins through three flops and update only on agreement.
  always @(posedge mclk) begin
    if (rst) begin
      s1_r <= {W{1'b1}};
      s2_r <= {W{1'b1}};
      s3_r <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // fsr_sync3

/* fsr_status.v */
`timescale 1ns/1ps
`include "fsr_defs.vh"
// Status register of the program/erase controller, with its read path.
module fsr_status (
  input wire mclk,
  input wire rst,
  input wire chip_en_n,
  input wire out_en_n,
  input wire [3:0] rd_bank,
  input wire burst_rd,
  input wire read_array_mode,
  input wire op_start,
  input wire op_is_erase,
  input wire [3:0] op_bank,
  input wire op_done,
  input wire op_prog_fail,
  input wire op_erase_fail,
  input wire op_block_locked,
  input wire vpp_ok,
  input wire blank_check_done,
  input wire [15:0] blank_check_word,
  input wire blank_check_word_vld,
  input wire suspend_cmd,
  input wire resume_cmd,
  input wire clear_status_cmd,
  input wire buffered_factory_programming_mode,
  input wire factory_buffer_ready,
  output reg [15:0] rd_data_r,
  output reg rd_is_status_r,
  output reg ctrl_paused_r,
  output reg op_abort_r
);
  localparam ST_IDLE = 2'b00;
  localparam ST_BUSY = 2'b01;
  localparam ST_SUSP_WAIT = 2'b10;
  localparam ST_SUSP = 2'b11;
  localparam [15:0] SUSP_CYC = `FSR_SUSP_CYC;

  wire [1:0] en_s;
  reg [1:0] en_d_r;
  reg [1:0] state_r;
  reg op_erase_r;
  reg [3:0] op_bank_r;
  reg [15:0] susp_cnt_r;
  reg esusp_r;
  reg psusp_r;
  reg echk_r;
  reg perr_r;
  reg verr_r;
  reg prot_r;
  reg blank_err_r;
  reg [7:0] status_nxt;
  wire en_fall;

  // The enables come from pins and are filtered before use.
  fsr_sync3 #(
    .W(2)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({chip_en_n, out_en_n}),
    .dout(en_s)
  );

  // Returns high when the bank-write bit must show another bank busy, or in factory mode the buffer not ready.
  function bank_bit;
    input busy;
    input factory;
    input buf_rdy;
    input [3:0] cur;
    input [3:0] rd;
    begin
      if (!busy) begin
        bank_bit = 1'b0;
      end else if (factory) begin
        bank_bit = !buf_rdy;
      end else begin
        bank_bit = (cur != rd);
      end
    end
  endfunction

  // Controller state: busy, pausing after suspend, and suspended.
  always @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_erase_r <= 1'b0;
      op_bank_r <= 4'h0;
      susp_cnt_r <= 16'h0000;
      esusp_r <= 1'b0;
      psusp_r <= 1'b0;
      ctrl_paused_r <= 1'b0;
      op_abort_r <= 1'b0;
    end else begin
      op_abort_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (op_start) begin
            op_bank_r <= op_bank;
            op_erase_r <= op_is_erase;
            if (!vpp_ok || op_block_locked) begin
              op_abort_r <= 1'b1;
            end else begin
              state_r <= ST_BUSY;
            end
          end
        end
        ST_BUSY: begin
          if (op_done) begin
            state_r <= ST_IDLE;
          end else if (suspend_cmd) begin
            state_r <= ST_SUSP_WAIT;
            susp_cnt_r <= 16'h0000;
          end
        end
        ST_SUSP_WAIT: begin
          if (op_done) begin
            state_r <= ST_IDLE;
          end else if (susp_cnt_r >= SUSP_CYC - 16'h0001) begin
            state_r <= ST_SUSP;
            ctrl_paused_r <= 1'b1;
            esusp_r <= op_erase_r;
            psusp_r <= !op_erase_r;
          end else begin
            susp_cnt_r <= susp_cnt_r + 16'h0001;
          end
        end
        ST_SUSP: begin
          if (resume_cmd) begin
            state_r <= ST_BUSY;
            ctrl_paused_r <= 1'b0;
            esusp_r <= 1'b0;
            psusp_r <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Blank check tracks any word that is not erased.
  always @(posedge mclk) begin
    if (rst) begin
      blank_err_r <= 1'b0;
    end else if (blank_check_done) begin
      blank_err_r <= 1'b0;
    end else if (blank_check_word_vld &&
                 blank_check_word != `FSR_ERASED_WORD) begin
      blank_err_r <= 1'b1;
    end
  end

  // Sticky error bits: a new failure wins over a clear in the same cycle.
  always @(posedge mclk) begin
    if (rst) begin
      {echk_r, perr_r, verr_r, prot_r} <= `FSR_RESET_ERR;
    end else begin
      if (clear_status_cmd) begin
        {echk_r, perr_r, verr_r, prot_r} <= `FSR_RESET_ERR;
      end
      if ((op_done && state_r != ST_IDLE && op_erase_r && op_erase_fail) ||
          (blank_check_done && (blank_err_r || (blank_check_word_vld &&
          blank_check_word != `FSR_ERASED_WORD)))) begin
        echk_r <= 1'b1;
      end
      if (op_done && state_r != ST_IDLE && !op_erase_r && op_prog_fail) begin
        perr_r <= 1'b1;
      end
      if (state_r == ST_IDLE && op_start && !vpp_ok) begin
        verr_r <= 1'b1;
      end
      if (state_r == ST_IDLE && op_start && op_block_locked) begin
        prot_r <= 1'b1;
      end
    end
  end

  // Assemble the live status byte with the idle bit on top.
  always @* begin
    status_nxt = 8'h00;
    status_nxt[`FSR_BIT_IDLE] = (state_r == ST_IDLE) ||
                                (state_r == ST_SUSP);
    status_nxt[`FSR_BIT_ESUSP] = esusp_r;
    status_nxt[`FSR_BIT_ECHK] = echk_r;
    status_nxt[`FSR_BIT_PERR] = perr_r;
    status_nxt[`FSR_BIT_VERR] = verr_r;
    status_nxt[`FSR_BIT_PSUSP] = psusp_r;
    status_nxt[`FSR_BIT_PROT] = prot_r;
    status_nxt[`FSR_BIT_BANK] = bank_bit(
      (state_r == ST_BUSY) || (state_r == ST_SUSP_WAIT),
      buffered_factory_programming_mode, factory_buffer_ready,
      op_bank_r, rd_bank);
  end

  // A fall of either filtered enable marks the start of a read.
  assign en_fall = (en_d_r[1] && !en_s[1]) || (en_d_r[0] && !en_s[0]);

  // Latch status on an enable fall and hold it until both enables rise.
  // Every bank answers single reads with status while neither read-array nor a burst is in force, so a
  // read from a quiet bank can show the bank-write bit report another bank.
  always @(posedge mclk) begin
    if (rst) begin
      en_d_r <= 2'b11;
      rd_data_r <= 16'h0000;
      rd_is_status_r <= 1'b0;
    end else begin
      en_d_r <= en_s;
      if (en_fall) begin
        if (!burst_rd && !read_array_mode) begin
          rd_data_r <= {8'h00, status_nxt};
          rd_is_status_r <= 1'b1;
        end else begin
          rd_is_status_r <= 1'b0;
        end
      end else if (en_s == 2'b11) begin
        rd_is_status_r <= 1'b0;
      end
    end
  end
endmodule // fsr_status

/* fsr_status_sva.sv */
`timescale 1ns/1ps
// Port checks for the status register block.
module fsr_status_sva (
  input wire mclk,
  input wire rst,
  input wire chip_en_n,
  input wire out_en_n,
  input wire burst_rd,
  input wire read_array_mode,
  input wire op_start,
  input wire suspend_cmd,
  input wire resume_cmd,
  input wire [15:0] rd_data_r,
  input wire rd_is_status_r,
  input wire ctrl_paused_r,
  input wire op_abort_r
);
  // All checks share one clock and its reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_hi; rd_data_r[15:8] == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("upper byte set");
  property p_drop; (chip_en_n && out_en_n) [*6] |-> !rd_is_status_r; endproperty
  a_drop: assert property (p_drop) else $error("status kept");
  property p_keep; (!chip_en_n && !out_en_n) [*6] ##0 rd_is_status_r
    |=> $stable(rd_data_r); endproperty
  a_keep: assert property (p_keep) else $error("status moved");
  property p_ref; (burst_rd || read_array_mode) [*7] |-> !rd_is_status_r;
  endproperty
  a_ref: assert property (p_ref) else $error("status given");
  property p_ab; op_abort_r |-> $past(op_start); endproperty
  a_ab: assert property (p_ab) else $error("abort no start");
  property p_abp; op_abort_r |=> !op_abort_r; endproperty
  a_abp: assert property (p_abp) else $error("abort long");
  property p_wait; suspend_cmd && !ctrl_paused_r |=> !ctrl_paused_r [*8];
  endproperty
  a_wait: assert property (p_wait) else $error("paused early");
  property p_res; ctrl_paused_r && resume_cmd |=> !ctrl_paused_r; endproperty
  a_res: assert property (p_res) else $error("resume lost");
  property p_hold; ctrl_paused_r && !resume_cmd |=> ctrl_paused_r; endproperty
  a_hold: assert property (p_hold) else $error("pause lost");
endmodule // fsr_status_sva

/* fsr_host.sv */
`timescale 1ns/1ps
// Host side of the flash bus, making single-word reads with both enables.
module fsr_host (
  input wire mclk,
  input wire [15:0] rd_data_r,
  input wire rd_is_status_r,
  output reg chip_en_n,
  output reg out_en_n
);
  // Enables idle high.
  initial begin
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
  end
  // One single read; a positive slow stretches the low phase.
  task automatic rd(input int slow, output logic [8:0] got);
    repeat (5) @(posedge mclk);
    #5 chip_en_n = 1'b0;
    out_en_n = 1'b0;
    repeat (5 + slow) @(posedge mclk);
    #1 got = {rd_is_status_r, rd_is_status_r ? rd_data_r[7:0] : 8'h00};
    #4 chip_en_n = 1'b1;
    out_en_n = 1'b1;
  endtask
endmodule // fsr_host

/* testbench.sv */
`timescale 1ns/1ps
// Drives operations and checks the status through host reads.
module testbench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] rd_bank = 4'h0;
  reg [3:0] op_bank = 4'h0;
  reg burst_rd = 0, read_array_mode = 0, op_is_erase = 0, pfail = 0;
  reg efail = 0, locked = 0, vpp_ok = 1, fmode = 0, buf_rdy = 0;
  reg [15:0] bc_word = 16'hFFFF;
  reg [6:0] p = 7'h00;
  reg [8:0] got;
  wire chip_en_n, out_en_n, rd_is_status_r, paused;
  wire [15:0] rd_data_r;
  integer bad_count = 0, check_count = 0;
  fsr_status fsr_status_inst (.mclk, .rst, .chip_en_n, .out_en_n, .rd_bank,
    .burst_rd, .read_array_mode, .op_start(p[0]), .op_is_erase, .op_bank,
    .op_done(p[1]), .op_prog_fail(pfail), .op_erase_fail(efail),
    .op_block_locked(locked), .vpp_ok, .blank_check_done(p[6]),
    .blank_check_word(bc_word), .blank_check_word_vld(p[5]),
    .suspend_cmd(p[2]), .resume_cmd(p[3]), .clear_status_cmd(p[4]),
    .buffered_factory_programming_mode(fmode), .factory_buffer_ready(buf_rdy),
    .rd_data_r, .rd_is_status_r, .ctrl_paused_r(paused), .op_abort_r());
  fsr_host fsr_host_inst (.mclk, .rd_data_r, .rd_is_status_r, .chip_en_n,
    .out_en_n);
  // Clock at 10 MHz.
  initial forever #50 mclk = ~mclk;
  // One-cycle command pulses.
  task pulse(input [6:0] v);
    @(posedge mclk);
    #5 p = v;
    @(posedge mclk);
    #5 p = 7'h00;
  endtask
  // Reads the status and compares valid flag with value.
  task chk(input [8:0] e);
    fsr_host_inst.rd(0, got);
    check_count++;
    if (got !== e) begin
      bad_count++;
      $display("[ERR] status expected %h seen %h", e, got);
    end
  endtask
  // Compares the paused level output against its expected value.
  task chk_bit(input e, input s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] paused expected %b seen %b", e, s);
    end
  endtask
  // Prints counts and the verdict.
  task finish_test;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge mclk);
    #5 rst = 1'b0;
    chk(9'h180);
    op_bank = 4'h2; rd_bank = 4'h2; pulse(7'h01);
    chk(9'h100);
    rd_bank = 4'h5; chk(9'h101);
    burst_rd = 1; chk(9'h000);
    burst_rd = 0; read_array_mode = 1; chk(9'h000);
    read_array_mode = 0; pfail = 1; pulse(7'h02); pfail = 0;
    chk(9'h190);
    chk(9'h190);
    pulse(7'h10); chk(9'h180);
    vpp_ok = 0; pulse(7'h01); vpp_ok = 1; chk(9'h188);
    pulse(7'h10); locked = 1; pulse(7'h01); locked = 0;
    chk(9'h182);
    pulse(7'h10); op_is_erase = 1; op_bank = 4'h1; rd_bank = 4'h1;
    pulse(7'h01); pulse(7'h04); chk(9'h100);
    repeat (200) @(posedge mclk);
    chk(9'h1C0);
    chk_bit(1'b1, paused);
    pulse(7'h08); chk(9'h100);
    chk_bit(1'b0, paused);
    efail = 1; pulse(7'h02); efail = 0; chk(9'h1A0);
    pulse(7'h10); op_is_erase = 0; pulse(7'h01); pulse(7'h04);
    repeat (210) @(posedge mclk);
    chk(9'h184);
    chk_bit(1'b1, paused);
    pulse(7'h08); pulse(7'h02); chk(9'h180);
    op_is_erase = 1; pulse(7'h01); pulse(7'h04); pulse(7'h02);
    repeat (210) @(posedge mclk);
    chk(9'h180);
    bc_word = 16'hFFFE; pulse(7'h20); pulse(7'h40); chk(9'h1A0);
    pulse(7'h10); chk(9'h180);
    fmode = 1; buf_rdy = 1; pulse(7'h01); chk(9'h100);
    buf_rdy = 0; chk(9'h101);
    vpp_ok = 0; chk(9'h101);
    vpp_ok = 1; pulse(7'h02); fmode = 0; chk(9'h180);
    vpp_ok = 0; pulse(7'h01); vpp_ok = 1;
    #100 rst = 1'b1;
    #100 rst = 1'b0;
    chk(9'h180);
    finish_test;
  end
  // Cuts a hang short.
  initial begin
    #500000;
    bad_count++;
    finish_test;
  end
endmodule // testbench
bind fsr_status fsr_status_sva fsr_status_sva_inst (.mclk, .rst, .chip_en_n,
  .out_en_n, .burst_rd, .read_array_mode, .op_start, .suspend_cmd,
  .resume_cmd, .rd_data_r, .rd_is_status_r, .ctrl_paused_r, .op_abort_r);
